// ---- src/dram_pkg.sv ----
// Purpose: Shared constants, bus carrier and state codes for the DRAM controller.
// Assumes: clk_sys at 125 MHz; times given in ns, except REFRESH_MAX_US in us.
// Notes: Cycle counts derive from the times here; rounding is ceiling (least times).
package dram_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 8;
  localparam int ROW_SETUP_NS = 16;
  localparam int CAS_DELAY_NS = 55;
  localparam int ROW_HOLD_NS = 24;
  localparam int REF_SETUP_NS = 24;
  localparam int REF_RAS_NS = 120;
  localparam int PRECHARGE_NS = 80;
  localparam int PROC_CLK_NS = 125;
  localparam int WAIT_STATES = 3;
  localparam int REFRESH_MAX_US = 15;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [5:0] ROW_SETUP_CYC = 6'(ns_to_cycles(ROW_SETUP_NS));
  localparam logic [5:0] CAS_DELAY_CYC = 6'(ns_to_cycles(CAS_DELAY_NS));
  localparam logic [5:0] ROW_HOLD_CYC = 6'(ns_to_cycles(ROW_HOLD_NS));
  localparam logic [5:0] REF_SETUP_CYC = 6'(ns_to_cycles(REF_SETUP_NS));
  localparam logic [5:0] REF_RAS_CYC = 6'(ns_to_cycles(REF_RAS_NS));
  localparam logic [5:0] PRECHARGE_CYC = 6'(ns_to_cycles(PRECHARGE_NS));
  localparam logic [5:0] SLOW_WAIT_CYC = 6'(ns_to_cycles(WAIT_STATES * PROC_CLK_NS));

  // ----------------------------------------
  // Refresh divider and row counter
  // ----------------------------------------
  localparam int REF_DIV_W = 4;
  localparam logic [3:0] REF_DIV_LAST = 4'hF;
  localparam int REF_ROW_W = 7;
  localparam logic [6:0] REF_ROW_RESET = 7'h00;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam int DRAM_ADDR_W = 8;
  localparam int ROW_LSB = 1;
  localparam int COL_LSB = 9;
  localparam int BANK_MSB = 19;
  localparam int BANK_LSB = 16;
  localparam logic [3:0] BANK0_CODE = 4'h0;
  localparam logic [3:0] BANK1_CODE = 4'h1;

  // Processor bus as seen at the pins
  typedef struct packed {
    logic [19:0] addr;
    logic high_byte_enable_n;
    logic mem_cycle;
    logic cycle_active_n;
    logic slow_select_n;
    logic fast_select_n;
  } bus_s;

  localparam bus_s BUS_IDLE = '{addr: 20'h00000, high_byte_enable_n: 1'b1,
    mem_cycle: 1'b0, cycle_active_n: 1'b1, slow_select_n: 1'b1, fast_select_n: 1'b1};

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ROW = 8'h02,
    ST_RAS = 8'h04,
    ST_CAS = 8'h08,
    ST_PRECHG = 8'h10,
    ST_REF_ADDR = 8'h20,
    ST_REF_RAS = 8'h40,
    ST_REF_END = 8'h80
  } ctl_state_e;

endpackage

// ---- src/refresh_timer.sv ----
// Purpose: Divide the peripheral clock into refresh requests and keep the refresh row.
// Assumes: periph_clk is a pin from another domain, far slower than clk_sys.
// Notes: The request is a one-cycle pulse on clk_sys.
`timescale 1ns/1ns
module refresh_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Peripheral clock pin
  input wire logic periph_clk,
  // Refresh side
  output logic refresh_request,
  output logic [dram_pkg::REF_ROW_W-1:0] refresh_row
);

  logic pclk_meta_q, pclk_sync_q, pclk_prev_q;
  logic [dram_pkg::REF_DIV_W-1:0] div_q, div_d;
  logic req_q, req_d;
  logic [dram_pkg::REF_ROW_W-1:0] row_q, row_d;
  logic rise;

  always_comb begin
    rise = pclk_sync_q & ~pclk_prev_q;
    div_d = rise ? div_q + 1'b1 : div_q;
    // Sixteen peripheral clock edges make one request
    req_d = rise && (div_q == dram_pkg::REF_DIV_LAST);
    // Each request advances the row; wraps after the last row
    row_d = req_d ? row_q + 1'b1 : row_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pclk_meta_q <= 1'b0;
      pclk_sync_q <= 1'b0;
      pclk_prev_q <= 1'b0;
      div_q <= '0;
      req_q <= 1'b0;
      row_q <= dram_pkg::REF_ROW_RESET;
    end else begin
      pclk_meta_q <= periph_clk;
      pclk_sync_q <= pclk_meta_q;
      pclk_prev_q <= pclk_sync_q;
      div_q <= div_d;
      req_q <= req_d;
      row_q <= row_d;
    end
  end

  assign refresh_request = req_q;
  assign refresh_row = row_q;

endmodule

// ---- src/ready_wait.sv ----
// Purpose: Wait-state timer for slow peripherals.
// Assumes: start stays high for the whole slow bus cycle.
// Notes: expired pulses once per cycle of start.
`timescale 1ns/1ns
module ready_wait (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic start,
  output logic expired
);

  logic [5:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    exp_d = 1'b0;
    if (!start) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (!done_q) begin
      // Three processor wait states before ready
      if (cnt_q == dram_pkg::SLOW_WAIT_CYC - 6'h01) begin
        exp_d = 1'b1;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule

// ---- src/dram_refresh_ready_control.sv ----
// Purpose: DRAM row/column control, row-only refresh and bus ready return.
// Assumes: Bus pins arrive from outside clk_sys and are synchronised here.
// Notes: One access or one refresh at a time; ready is a one-cycle low pulse.
//
// How it works
// - Sixteen RAM address bits go out as eight row then eight column bits.
// - Row bits stand on the DRAM lines before the row strobe falls.
// - Column bits replace the row bits before the column strobe falls.
// - Column strobe falls 55 ns after the row strobe on processor access; the code takes seven cycles, 56 ns.
// - Low lane strobe on address bit zero low, high lane on high enable low.
// - 128K bytes of DRAM sit at byte addresses 00000 to 1FFFF.
// - All 128 rows are refreshed within every 2 ms.
// - Refresh drives only the row strobe, column strobes stay high.
// - One row refresh is scheduled at least every 15 us.
// - Refresh request comes from the peripheral clock divided by sixteen.
// - Each request marks refresh pending and advances the refresh row.
// - Grant only while refresh is pending and RAM is not selected.
// - RAM selected during refresh gets no ready until refresh ends.
// - After grant, refresh row goes on the lines, then strobe after setup.
// - Grant drops after the refresh row is strobed in.
// - Addressed circuits return ready; the processor waits for ready low.
// - RAM, ROM, video RAM and vector reads get ready without waits.
// - Slow peripherals get three wait states before ready.
// - RAM select is two 64K banks, 00000-0FFFF and 10000-1FFFF.
// - Ready is active low and generated on the system clock.
// - Processor-side control runs from the system clock.
`timescale 1ns/1ns
module dram_refresh_ready_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Processor bus pins
  input wire dram_pkg::bus_s bus_in,
  // Peripheral clock pin
  input wire logic periph_clk,
  // DRAM pins
  output logic [dram_pkg::DRAM_ADDR_W-1:0] dram_addr,
  output logic row_strobe_n,
  output logic column_strobe_low_byte_n,
  output logic column_strobe_high_byte_n,
  // Ready return
  output logic ready_n,
  // Refresh status
  output logic refresh_grant,
  output logic refresh_addr_enable,
  output logic refresh_row_strobe
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  dram_pkg::bus_s bus_meta_q, bus_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_meta_q <= dram_pkg::BUS_IDLE;
      bus_q <= dram_pkg::BUS_IDLE;
    end else begin
      bus_meta_q <= bus_in;
      bus_q <= bus_meta_q;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic cyc, ram_sel, fast_sel, slow_sel;
  logic [3:0] bank;

  always_comb begin
    cyc = !bus_q.cycle_active_n;
    bank = bus_q.addr[dram_pkg::BANK_MSB:dram_pkg::BANK_LSB];
    // Two 64K banks make the 128K window
    ram_sel = cyc && bus_q.mem_cycle &&
              (bank == dram_pkg::BANK0_CODE || bank == dram_pkg::BANK1_CODE);
    fast_sel = cyc && !bus_q.fast_select_n;
    slow_sel = cyc && !bus_q.slow_select_n;
  end

  // ----------------------------------------
  // Refresh source and slow wait timer
  // ----------------------------------------
  logic ref_req;
  logic [dram_pkg::REF_ROW_W-1:0] ref_row;
  logic slow_expired;

  refresh_timer u_refresh_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .periph_clk(periph_clk),
    .refresh_request(ref_req),
    .refresh_row(ref_row)
  );

  ready_wait u_ready_wait (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(slow_sel),
    .expired(slow_expired)
  );

  // ----------------------------------------
  // Access and refresh sequencer
  // ----------------------------------------
  dram_pkg::ctl_state_e st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic served_q, served_d;
  logic [7:0] addr_q, addr_d;
  logic ras_n_q, ras_n_d;
  logic column_strobe_low_byte_n_n_q, column_strobe_low_byte_n_n_d;
  logic column_strobe_high_byte_n_n_q, column_strobe_high_byte_n_n_d;
  logic rdy_n_q, rdy_n_d;
  logic gnt_q, gnt_d;
  logic rae_q, rae_d;
  logic refresh_row_strobe_q, refresh_row_strobe_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 6'h01;
    addr_d = addr_q;
    ras_n_d = ras_n_q;
    column_strobe_low_byte_n_n_d = 1'b1;
    column_strobe_high_byte_n_n_d = 1'b1;
    rdy_n_d = 1'b1;
    gnt_d = gnt_q;
    rae_d = rae_q;
    refresh_row_strobe_d = 1'b0;
    served_d = served_q && cyc;
    // A new request wins over the clear at refresh end
    pend_d = pend_q;
    case (st_q)
      dram_pkg::ST_IDLE: begin
        cnt_d = '0;
        ras_n_d = 1'b1;
        if (pend_q && !ram_sel) begin
          // Grant only with RAM idle
          st_d = dram_pkg::ST_REF_ADDR;
          gnt_d = 1'b1;
          rae_d = 1'b1;
          addr_d = {1'b0, ref_row};
        end else if (ram_sel && !served_q) begin
          st_d = dram_pkg::ST_ROW;
          // Row bits first
          addr_d = bus_q.addr[dram_pkg::ROW_LSB +: dram_pkg::DRAM_ADDR_W];
        end
      end
      dram_pkg::ST_ROW: begin
        if (cnt_q == dram_pkg::ROW_SETUP_CYC - 6'h01) begin
          st_d = dram_pkg::ST_RAS;
          cnt_d = '0;
          ras_n_d = 1'b0;
        end
      end
      dram_pkg::ST_RAS: begin
        // Column bits after the row hold, well before the column strobe
        if (cnt_q == dram_pkg::ROW_HOLD_CYC - 6'h01) begin
          addr_d = bus_q.addr[dram_pkg::COL_LSB +: dram_pkg::DRAM_ADDR_W];
        end
        // Column strobe is the row strobe delayed by seven cycles, 56 ns
        if (cnt_q == dram_pkg::CAS_DELAY_CYC - 6'h01) begin
          st_d = dram_pkg::ST_CAS;
          column_strobe_low_byte_n_n_d = bus_q.addr[0];
          column_strobe_high_byte_n_n_d = bus_q.high_byte_enable_n;
          // No wait states beyond the access itself
          rdy_n_d = 1'b0;
          served_d = 1'b1;
        end
      end
      dram_pkg::ST_CAS: begin
        column_strobe_low_byte_n_n_d = column_strobe_low_byte_n_n_q;
        column_strobe_high_byte_n_n_d = column_strobe_high_byte_n_n_q;
        // Hold the strobes until the processor ends the cycle
        if (!ram_sel) begin
          st_d = dram_pkg::ST_PRECHG;
          cnt_d = '0;
          ras_n_d = 1'b1;
          column_strobe_low_byte_n_n_d = 1'b1;
          column_strobe_high_byte_n_n_d = 1'b1;
        end
      end
      dram_pkg::ST_REF_ADDR: begin
        // Refresh row stands on the lines for its setup time
        if (cnt_q == dram_pkg::REF_SETUP_CYC - 6'h01) begin
          st_d = dram_pkg::ST_REF_RAS;
          cnt_d = '0;
          ras_n_d = 1'b0;
          refresh_row_strobe_d = 1'b1;
        end
      end
      dram_pkg::ST_REF_RAS: begin
        // Only the row strobe moves; column strobes stay high
        refresh_row_strobe_d = 1'b1;
        if (cnt_q == dram_pkg::REF_RAS_CYC - 6'h01) begin
          st_d = dram_pkg::ST_REF_END;
          cnt_d = '0;
          ras_n_d = 1'b1;
          refresh_row_strobe_d = 1'b0;
          rae_d = 1'b0;
          gnt_d = 1'b0;
          pend_d = 1'b0;
        end
      end
      dram_pkg::ST_REF_END, dram_pkg::ST_PRECHG: begin
        // Row strobe precharge before any new access or refresh
        if (cnt_q == dram_pkg::PRECHARGE_CYC - 6'h01) begin
          st_d = dram_pkg::ST_IDLE;
          cnt_d = '0;
        end
      end
      default: begin
        st_d = dram_pkg::ST_IDLE;
        cnt_d = '0;
        ras_n_d = 1'b1;
        gnt_d = 1'b0;
        rae_d = 1'b0;
      end
    endcase
    if (ref_req) begin
      pend_d = 1'b1;
    end
    // While refresh runs a RAM cycle simply gets no ready yet
    if (!served_q && !rdy_n_q == 1'b0 && (fast_sel || slow_expired) && !ram_sel) begin
      // Fast targets answer at once, slow ones after the timer
      rdy_n_d = 1'b0;
      served_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= dram_pkg::ST_IDLE;
      cnt_q <= '0;
      pend_q <= 1'b0;
      served_q <= 1'b0;
      addr_q <= '0;
      ras_n_q <= 1'b1;
      column_strobe_low_byte_n_n_q <= 1'b1;
      column_strobe_high_byte_n_n_q <= 1'b1;
      rdy_n_q <= 1'b1;
      gnt_q <= 1'b0;
      rae_q <= 1'b0;
      refresh_row_strobe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      served_q <= served_d;
      addr_q <= addr_d;
      ras_n_q <= ras_n_d;
      column_strobe_low_byte_n_n_q <= column_strobe_low_byte_n_n_d;
      column_strobe_high_byte_n_n_q <= column_strobe_high_byte_n_n_d;
      rdy_n_q <= rdy_n_d;
      gnt_q <= gnt_d;
      rae_q <= rae_d;
      refresh_row_strobe_q <= refresh_row_strobe_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dram_addr = addr_q;
  assign row_strobe_n = ras_n_q;
  assign column_strobe_low_byte_n = column_strobe_low_byte_n_n_q;
  assign column_strobe_high_byte_n = column_strobe_high_byte_n_n_q;
  assign ready_n = rdy_n_q;
  assign refresh_grant = gnt_q;
  assign refresh_addr_enable = rae_q;
  assign refresh_row_strobe = refresh_row_strobe_q;

endmodule

// ---- verif/dram_ctl_properties.sv ----
// Purpose: Pin timing checks for the DRAM controller.
// Assumes: Bound to dram_refresh_ready_control; bus pins seen before sync.
// Notes: Cycle figures follow the design's 8 ns clock.
`timescale 1ns/1ns
module dram_ctl_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Inputs
  input wire dram_pkg::bus_s bus_in,
  input wire logic periph_clk,
  // Outputs
  input wire logic [dram_pkg::DRAM_ADDR_W-1:0] dram_addr,
  input wire logic row_strobe_n,
  input wire logic column_strobe_low_byte_n,
  input wire logic column_strobe_high_byte_n,
  input wire logic ready_n,
  input wire logic refresh_grant,
  input wire logic refresh_addr_enable,
  input wire logic refresh_row_strobe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_cas_fell;
    $fell(column_strobe_low_byte_n) || $fell(column_strobe_high_byte_n);
  endsequence
  property p_cas_delay;
    s_cas_fell |-> !$past(row_strobe_n, 7) && $past(row_strobe_n, 8);
  endproperty
  property p_col_setup;
    s_cas_fell |-> $stable(dram_addr);
  endproperty
  property p_row_setup;
    $fell(row_strobe_n) |-> $stable(dram_addr);
  endproperty
  property p_lane_low;
    $fell(column_strobe_low_byte_n) |-> !bus_in.addr[0];
  endproperty
  property p_ref_only_ras;
    refresh_row_strobe |->
      !row_strobe_n && column_strobe_low_byte_n && column_strobe_high_byte_n;
  endproperty
  property p_ref_setup;
    $rose(refresh_grant) |->
      refresh_addr_enable ##0 row_strobe_n[*3] ##1 (refresh_row_strobe && !row_strobe_n);
  endproperty
  property p_ref_end;
    $rose(refresh_row_strobe) |-> refresh_grant[*8] ##8 (!refresh_grant && row_strobe_n);
  endproperty
  property p_ref_addr;
    refresh_addr_enable && $past(refresh_addr_enable) |->
      refresh_grant && $stable(dram_addr) && !dram_addr[7];
  endproperty
  property p_ready_pulse;
    !ready_n |=> ready_n;
  endproperty
  // Raw pins lead the design by two cycles, so only an open RAM cycle counts
  property p_ref_blocks_ready;
    refresh_grant && !bus_in.cycle_active_n && bus_in.mem_cycle &&
      bus_in.addr[19:17] == 3'h0 |-> ready_n;
  endproperty

  a_cas_delay: assert property (p_cas_delay) else $error("column strobe delay wrong");
  a_col_setup: assert property (p_col_setup) else $error("column addr moved");
  a_row_setup: assert property (p_row_setup) else $error("row addr moved");
  a_lane_low: assert property (p_lane_low) else $error("low lane strobe wrong");
  a_ref_only_ras: assert property (p_ref_only_ras) else $error("refresh strobes wrong");
  a_ref_setup: assert property (p_ref_setup) else $error("refresh setup wrong");
  a_ref_end: assert property (p_ref_end) else $error("grant end wrong");
  a_ref_addr: assert property (p_ref_addr) else $error("refresh addr moved");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  a_ref_blocks_ready: assert property (p_ref_blocks_ready) else $error("ready in refresh");

  c_refresh: cover property ($rose(refresh_grant));
  c_word: cover property ($fell(column_strobe_low_byte_n) && $fell(column_strobe_high_byte_n));
  c_slow: cover property ($fell(ready_n) && !bus_in.slow_select_n);
endmodule

// ---- verif/proc_bus_model.sv ----
// Purpose: Processor bus side: opens one cycle, waits for ready, closes it.
// Assumes: The bench raises go for one cycle per transfer.
// Notes: Released lines carry inverted values, not the old address.
`timescale 1ns/1ns
module proc_bus_model (
  // Clock
  input wire logic clk_sys,
  // Request from the bench
  input wire logic go,
  input wire dram_pkg::bus_s cmd,
  input wire logic [9:0] hold,
  // Bus side
  input wire logic ready_n,
  output dram_pkg::bus_s bus,
  output logic done,
  output logic [7:0] waits
);
  initial begin
    bus = dram_pkg::BUS_IDLE;
    done = 1'b0;
    waits = 8'h00;
    forever begin
      @(negedge clk_sys);
      if (go === 1'b1) begin
        done = 1'b0;
        bus = cmd;
        bus.cycle_active_n = 1'b0;
        waits = 8'h00;
        // Ready is read half a cycle after it launches, never on its own edge
        do begin
          @(negedge clk_sys);
          waits = waits + 8'h01;
        end while (ready_n !== 1'b0);
        repeat (hold) @(negedge clk_sys);
        @(negedge clk_sys);
        bus = ~cmd;
        bus.cycle_active_n = 1'b1;
        bus.slow_select_n = 1'b1;
        bus.fast_select_n = 1'b1;
        bus.mem_cycle = 1'b0;
        done = 1'b1;
      end
    end
  end
endmodule

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the DRAM refresh and ready control.
// Assumes: Peripheral clock stepped on clk_sys falling edges, exact 4 MHz mean.
// Notes: The refresh walk covers all 128 rows, so the run is about 70k cycles.
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic periph_clk = 1'b0;
  logic go = 1'b0;
  logic [9:0] hold = 10'h000;
  dram_pkg::bus_s bus_in;
  dram_pkg::bus_s cmd;
  logic done;
  logic [7:0] waits, dram_addr, row_seen, col_seen;
  logic row_strobe_n, column_strobe_low_byte_n, column_strobe_high_byte_n, ready_n;
  logic refresh_grant, refresh_addr_enable, refresh_row_strobe;
  logic [1:0] lanes;
  int fails = 0, compares = 0, cyc = 0, cas_falls = 0, t_gfall = 0, t_rdy = 0, pacc = 0;

  dram_refresh_ready_control i_dram_refresh_ready_control (.clk_sys, .reset_n, .bus_in,
    .periph_clk, .dram_addr, .row_strobe_n, .column_strobe_low_byte_n,
    .column_strobe_high_byte_n, .ready_n, .refresh_grant, .refresh_addr_enable,
    .refresh_row_strobe);
  proc_bus_model i_proc_bus_model (.clk_sys, .go, .cmd, .hold, .ready_n, .bus(bus_in),
    .done, .waits);

  always #4 clk_sys = ~clk_sys;
  // 125 ns half period on an 8 ns grid keeps the 16-period interval exact
  always @(negedge clk_sys) begin
    cyc++;
    pacc = pacc + 8;
    if (pacc >= 125) begin
      pacc = pacc - 125;
      periph_clk = ~periph_clk;
    end
    if (ready_n === 1'b0) begin
      lanes = {column_strobe_high_byte_n, column_strobe_low_byte_n};
      t_rdy = cyc;
    end
    if (cyc == 90000) begin
      fails++;
      finish_test();
    end
  end
  always @(negedge row_strobe_n) row_seen = dram_addr;
  always @(negedge column_strobe_low_byte_n or negedge column_strobe_high_byte_n) begin
    col_seen = dram_addr;
    cas_falls++;
  end
  always @(negedge refresh_grant) t_gfall = cyc;

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // kind is {mem_cycle, slow_select_n, fast_select_n}
  task automatic access(input logic [19:0] a, input logic [2:0] kind, input logic bhe_n,
                        input logic [9:0] h);
    cmd = dram_pkg::BUS_IDLE;
    cmd.addr = a;
    cmd.high_byte_enable_n = bhe_n;
    {cmd.mem_cycle, cmd.slow_select_n, cmd.fast_select_n} = kind;
    hold = h;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    while (done !== 1'b1) @(posedge clk_sys);
  endtask

  task automatic wait_grant(input logic want);
    while (refresh_grant !== want) @(negedge clk_sys);
  endtask

  task automatic t_refresh;
    logic [6:0] row;
    int t;
    wait_grant(1'b1);
    chk(dram_addr, 20'h00001);
    row = 7'h01;
    t = cyc;
    repeat (129) begin
      wait_grant(1'b0);
      wait_grant(1'b1);
      row = row + 7'h01;
      chk(dram_addr, {1'b0, row});
      chk(20'(cyc - t), 20'h001F4);
      t = cyc;
    end
    $display("test refresh done");
  endtask

  task automatic t_ram(input logic [19:0] a, input logic bhe_n);
    wait_grant(1'b1);
    wait_grant(1'b0);
    repeat (12) @(negedge clk_sys);
    access(a, 3'b111, bhe_n, 10'h000);
    chk(row_seen, a[8:1]);
    chk(col_seen, a[16:9]);
    chk(lanes, {bhe_n, a[0]});
    chk(20'(waits <= 8'h12), 20'h1);
    $display("test ram %h done", a);
  endtask

  task automatic t_io;
    int f;
    f = cas_falls;
    access(20'h20000, 3'b110, 1'b0, 10'h000);
    chk(20'(waits <= 8'h06), 20'h1);
    chk(20'(cas_falls - f), 20'h0);
    repeat (2) begin
      access(20'h04000, 3'b001, 1'b0, 10'h000);
      chk(20'(waits >= 8'h32 && waits <= 8'h38), 20'h1);
    end
    $display("test io done");
  endtask

  task automatic t_collide;
    wait_grant(1'b0);
    wait_grant(1'b1);
    access(20'h00100, 3'b111, 1'b0, 10'h000);
    chk(20'(t_rdy > t_gfall), 20'h1);
    $display("test collide done");
  endtask

  task automatic t_hold;
    int f, n;
    wait_grant(1'b1);
    wait_grant(1'b0);
    repeat (12) @(negedge clk_sys);
    f = t_gfall;
    access(20'h10010, 3'b111, 1'b0, 10'h258);
    chk(20'(t_gfall), 20'(f));
    n = 0;
    while (refresh_grant !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk(refresh_grant, 20'h1);
    $display("test hold done");
  endtask

  task automatic finish_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    cmd = dram_pkg::BUS_IDLE;
    repeat (4) @(negedge clk_sys);
    chk({row_strobe_n, column_strobe_low_byte_n, column_strobe_high_byte_n, ready_n},
        20'h0000F);
    chk({refresh_grant, refresh_addr_enable, refresh_row_strobe}, 20'h0);
    $display("test reset done");
    reset_n = 1'b1;
    t_refresh();
    t_ram(20'h00000, 1'b0);
    t_ram(20'h1FFFE, 1'b0);
    t_ram(20'h0A5C3, 1'b0);
    t_ram(20'h1B5A4, 1'b1);
    t_io();
    t_collide();
    t_hold();
    finish_test();
  end
endmodule

bind dram_refresh_ready_control dram_ctl_properties i_dram_ctl_properties (.clk_sys,
  .reset_n, .bus_in, .periph_clk, .dram_addr, .row_strobe_n, .column_strobe_low_byte_n,
  .column_strobe_high_byte_n, .ready_n, .refresh_grant, .refresh_addr_enable,
  .refresh_row_strobe);
